// file: hdl/faas_cycle.sv
`timescale 1ns/1ps
`default_nettype none
// One timed read or write strobe on the flash pins
module faas_cycle
(
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 start,
  input  wire logic                 wr,
  input  wire logic [18:0]          addr,
  input  wire logic [7:0]           wdata,
  input  wire logic [7:0]           dq_i,
  output var  faas_pkg::faas_pins_t pins,
  output logic                      done,
  output logic [7:0]                rdata
);

  typedef enum {C_IDLE, C_STROBE, C_RECOVER} faas_cyc_state_t;

  faas_cyc_state_t      state;       // Strobe phase
  faas_cyc_state_t      next_state;
  logic [3:0]           cnt;         // Cycles left in phase
  logic [3:0]           next_cnt;
  faas_pkg::faas_pins_t next_pins;
  logic                 next_done;
  logic [7:0]           next_rdata;

  // Next-state logic of the strobe engine
  always_comb
  begin
    next_state = state;
    next_cnt   = cnt;
    next_pins  = pins;
    next_done  = 1'b0;
    next_rdata = rdata;
    case (state)
      C_IDLE:
      begin
        // Start only ever arrives here; the caller waits for done
        if (start)
        begin
          next_pins.addr = addr;
          next_pins.ce_n = 1'b0;
          if (wr)
          begin
            next_pins.we_n  = 1'b0;
            next_pins.dq_o  = wdata;
            next_pins.dq_oe = 1'b1;
            next_cnt        = 4'(faas_pkg::WRITE_PULSE_CYC - 1);
          end
          else
          begin
            next_pins.oe_n = 1'b0;
            next_cnt       = 4'(faas_pkg::READ_ACCESS_CYC - 1);
          end
          next_state = C_STROBE;
        end
      end
      C_STROBE:
      begin
        if (cnt == 4'h0)
        begin
          // Data sampled in the last cycle of the access
          if (pins.we_n)
            next_rdata = dq_i;
          next_pins.ce_n = 1'b1;
          next_pins.oe_n = 1'b1;
          next_pins.we_n = 1'b1;
          next_cnt       = 4'(faas_pkg::RECOVER_CYC - 1);
          next_state     = C_RECOVER;
        end
        else
          next_cnt = cnt - 4'h1;
      end
      C_RECOVER:
      begin
        // Bus let go one cycle after the strobe rises, so data holds
        next_pins.dq_oe = 1'b0;
        if (cnt == 4'h0)
        begin
          next_done  = 1'b1;
          next_state = C_IDLE;
        end
        else
          next_cnt = cnt - 4'h1;
      end
      default:
        next_state = C_IDLE;
    endcase
  end

  // Registers of the strobe engine
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state <= C_IDLE;
      cnt   <= 4'h0;
      pins  <= faas_pkg::PINS_IDLE;
      done  <= 1'b0;
      rdata <= 8'h00;
    end
    else
    begin
      state <= next_state;
      cnt   <= next_cnt;
      pins  <= next_pins;
      done  <= next_done;
      rdata <= next_rdata;
    end
  end

endmodule
`default_nettype wire

// file: hdl/faas_host.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Completion found by polling status reads
// - Hold reset low at least 500 ns
// - Reset high 50 ns before read
// - Unprotect level 4 us before write
// - Access may follow ready immediately
module faas_host
#(
  parameter int unsigned PROG_TIMEOUT_CYC  = faas_pkg::PROG_TIMEOUT_CYC,
  parameter int unsigned ERASE_TIMEOUT_CYC = faas_pkg::ERASE_TIMEOUT_CYC
)
(
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 req_valid,
  input  wire faas_pkg::faas_req_t  req,
  output logic                      req_ready,
  output logic                      rsp_valid,
  output var  faas_pkg::faas_rsp_t  rsp,
  output var  faas_pkg::faas_pins_t flash_pins,
  input  wire logic [7:0]           dq_i,
  input  wire logic                 ready_busy_n_out,
  output logic                      flash_reset_n,
  output logic                      unprotect_hv_en
);

  typedef enum {S_IDLE, S_SEQ, S_POLL1, S_POLL2, S_READ,
                S_RST_LOW, S_RST_HIGH, S_HV_WAIT, S_RESP} faas_state_t;

  faas_state_t         state;          // Sequencer state
  faas_state_t         next_state;
  faas_pkg::faas_op_t  op;             // Operation in hand
  faas_pkg::faas_op_t  next_op;
  logic [18:0]         addr;           // Target address
  logic [18:0]         next_addr;
  logic [7:0]          wdata;          // Byte to program
  logic [7:0]          next_wdata;
  logic [2:0]          step;           // Command sequence index
  logic [2:0]          next_step;
  logic [29:0]         timer;          // Wait or time-out down counter
  logic [29:0]         next_timer;
  logic [7:0]          stat0;          // First of two status reads
  logic [7:0]          next_stat0;
  logic                issued;         // Bus cycle under way
  logic                next_issued;
  logic                cyc_start;      // Bus cycle request pulse
  logic                next_cyc_start;
  logic                cyc_wr;
  logic                next_cyc_wr;
  logic [18:0]         cyc_addr;
  logic [18:0]         next_cyc_addr;
  logic [7:0]          cyc_wdata;
  logic [7:0]          next_cyc_wdata;
  logic                cyc_done;       // Bus cycle finished
  logic [7:0]          cyc_rdata;      // Byte read by last cycle
  logic                next_req_ready;
  logic                next_rsp_valid;
  faas_pkg::faas_rsp_t next_rsp;
  logic                next_flash_reset_n;
  logic                next_unprotect_hv_en;
  logic [26:0]         seq_word;       // Address and data of current step
  logic                poll_done;      // Status shows the algorithm over

  // Address and data of one step of a command sequence
  function automatic logic [26:0] seq_entry(input faas_pkg::faas_op_t o,
                                            input logic [2:0] idx,
                                            input logic [18:0] a,
                                            input logic [7:0] d);
    logic [26:0] w;
    w = {faas_pkg::UNLOCK_ADDR1, faas_pkg::UNLOCK_DATA1};
    case (idx)
      3'h1: w = {faas_pkg::UNLOCK_ADDR2, faas_pkg::UNLOCK_DATA2};
      3'h2: w = {faas_pkg::UNLOCK_ADDR1, (o == faas_pkg::OP_PROGRAM) ?
                 faas_pkg::CMD_PROGRAM : faas_pkg::CMD_ERASE_SETUP};
      // Program ends on its single byte, no verify write follows
      3'h3: if (o == faas_pkg::OP_PROGRAM) w = {a, d};
      3'h4: w = {faas_pkg::UNLOCK_ADDR2, faas_pkg::UNLOCK_DATA2};
      3'h5:
        if (o == faas_pkg::OP_CHIP_ERASE)
          w = {faas_pkg::UNLOCK_ADDR1, faas_pkg::CMD_CHIP_ERASE};
        else
          w = {a[faas_pkg::SECTOR_SELECT_HIGH_BIT:faas_pkg::SECTOR_SELECT_LOW_BIT],
               13'h0000, faas_pkg::CMD_SECTOR_ERASE};
      default: w = {faas_pkg::UNLOCK_ADDR1, faas_pkg::UNLOCK_DATA1};
    endcase
    return w;
  endfunction

  // Pin-level read and write strobes
  faas_cycle u_cycle
  (
    .clk   (clk),
    .reset (reset),
    .start (cyc_start),
    .wr    (cyc_wr),
    .addr  (cyc_addr),
    .wdata (cyc_wdata),
    .dq_i  (dq_i),
    .pins  (flash_pins),
    .done  (cyc_done),
    .rdata (cyc_rdata)
  );

  // Step word and completion test on the second status read
  always_comb
  begin
    seq_word  = seq_entry(op, step, addr, wdata);
    // Toggle bit steady across two reads, with the poll bit at its final value, ends the algorithm
    poll_done = (cyc_rdata[faas_pkg::TOGGLE_STATUS_BIT] ==
                 stat0[faas_pkg::TOGGLE_STATUS_BIT]);
    if (op == faas_pkg::OP_PROGRAM)
      poll_done = poll_done && (cyc_rdata[faas_pkg::POLL_STATUS_BIT] ==
                                wdata[faas_pkg::POLL_STATUS_BIT]);
    else
      poll_done = poll_done && cyc_rdata[faas_pkg::POLL_STATUS_BIT];
  end

  // Next values of the sequencer
  always_comb
  begin
    next_state           = state;
    next_op              = op;
    next_addr            = addr;
    next_wdata           = wdata;
    next_step            = step;
    next_timer           = timer;
    next_stat0           = stat0;
    next_issued          = issued;
    next_cyc_start       = 1'b0;
    next_cyc_wr          = cyc_wr;
    next_cyc_addr        = cyc_addr;
    next_cyc_wdata       = cyc_wdata;
    next_rsp_valid       = 1'b0;
    next_rsp             = rsp;
    next_flash_reset_n   = flash_reset_n;
    next_unprotect_hv_en = unprotect_hv_en;
    case (state)
      S_IDLE:
      begin
        if (req_valid && req_ready)
        begin
          next_op    = req.op;
          next_addr  = req.addr;
          next_wdata = req.data;
          next_step  = 3'h0;
          next_rsp   = '0;
          case (req.op)
            faas_pkg::OP_READ:
              next_state = S_READ;
            faas_pkg::OP_RESET:
            begin
              next_flash_reset_n = 1'b0;
              next_timer         = 30'(faas_pkg::RST_PULSE_CYC - 1);
              next_state         = S_RST_LOW;
            end
            faas_pkg::OP_UNPROT_ON:
            begin
              next_unprotect_hv_en = 1'b1;
              next_timer = 30'(faas_pkg::UNPROTECT_SETUP_CYC - 1);
              next_state = S_HV_WAIT;
            end
            faas_pkg::OP_UNPROT_OFF:
            begin
              next_unprotect_hv_en = 1'b0;
              next_timer = 30'(faas_pkg::UNPROTECT_RAMP_CYC - 1);
              next_state = S_HV_WAIT;
            end
            default:
              next_state = S_SEQ;
          endcase
        end
      end
      S_SEQ:
      begin
        // One write per step, next step only once the strobe is done
        if (!issued)
        begin
          next_issued    = 1'b1;
          next_cyc_start = 1'b1;
          next_cyc_wr    = 1'b1;
          next_cyc_addr  = seq_word[26:8];
          next_cyc_wdata = seq_word[7:0];
        end
        else if (cyc_done)
        begin
          next_issued = 1'b0;
          if (step == ((op == faas_pkg::OP_PROGRAM) ? faas_pkg::PROG_SEQ_LAST :
                                                       faas_pkg::ERASE_SEQ_LAST))
          begin
            next_timer = (op == faas_pkg::OP_PROGRAM) ? 30'(PROG_TIMEOUT_CYC) :
                                                        30'(ERASE_TIMEOUT_CYC);
            next_state = S_POLL1;
          end
          else
            next_step = step + 3'h1;
        end
      end
      S_POLL1, S_POLL2:
      begin
        // Plain reads while the algorithm runs; busy pin not needed
        if (timer != 30'h0)
          next_timer = timer - 30'h1;
        if (!issued)
        begin
          next_issued    = 1'b1;
          next_cyc_start = 1'b1;
          next_cyc_wr    = 1'b0;
          next_cyc_addr  = addr;
        end
        else if (cyc_done)
        begin
          next_issued = 1'b0;
          next_stat0  = cyc_rdata;
          if (state == S_POLL1)
            next_state = S_POLL2;
          else if (poll_done)
          begin
            next_rsp.data = cyc_rdata;
            next_state    = S_RESP;
          end
          else if (timer == 30'h0)
          begin
            // Algorithm overran its longest time; host gives up
            next_rsp.data    = cyc_rdata;
            next_rsp.timeout = 1'b1;
            next_state       = S_RESP;
          end
          else
            next_state = S_POLL2;
        end
      end
      S_READ:
      begin
        // Array data only once ready; no delay needed after it rises
        if (!issued && ready_busy_n_out)
        begin
          next_issued    = 1'b1;
          next_cyc_start = 1'b1;
          next_cyc_wr    = 1'b0;
          next_cyc_addr  = addr;
        end
        else if (issued && cyc_done)
        begin
          next_issued   = 1'b0;
          next_rsp.data = cyc_rdata;
          next_state    = S_RESP;
        end
      end
      S_RST_LOW:
      begin
        if (timer == 30'h0)
        begin
          next_flash_reset_n = 1'b1;
          // Wait out the worst abort time, which covers the high time too
          next_timer = 30'(faas_pkg::READY_ALGO_CYC - faas_pkg::RST_PULSE_CYC - 1);
          next_state = S_RST_HIGH;
        end
        else
          next_timer = timer - 30'h1;
      end
      S_RST_HIGH, S_HV_WAIT:
      begin
        if (timer == 30'h0)
          next_state = S_RESP;
        else
          next_timer = timer - 30'h1;
      end
      S_RESP:
      begin
        next_rsp_valid = 1'b1;
        next_state     = S_IDLE;
      end
      default:
        next_state = S_IDLE;
    endcase
    next_req_ready = (next_state == S_IDLE) && !next_rsp_valid;
  end

  // Sequencer registers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state           <= S_IDLE;
      op              <= faas_pkg::OP_READ;
      addr            <= 19'h00000;
      wdata           <= 8'h00;
      step            <= 3'h0;
      timer           <= 30'h00000000;
      stat0           <= 8'h00;
      issued          <= 1'b0;
      cyc_start       <= 1'b0;
      cyc_wr          <= 1'b0;
      cyc_addr        <= 19'h00000;
      cyc_wdata       <= 8'h00;
      req_ready       <= 1'b0;
      rsp_valid       <= 1'b0;
      rsp             <= '0;
      flash_reset_n   <= 1'b1;
      unprotect_hv_en <= 1'b0;
    end
    else
    begin
      state           <= next_state;
      op              <= next_op;
      addr            <= next_addr;
      wdata           <= next_wdata;
      step            <= next_step;
      timer           <= next_timer;
      stat0           <= next_stat0;
      issued          <= next_issued;
      cyc_start       <= next_cyc_start;
      cyc_wr          <= next_cyc_wr;
      cyc_addr        <= next_cyc_addr;
      cyc_wdata       <= next_cyc_wdata;
      req_ready       <= next_req_ready;
      rsp_valid       <= next_rsp_valid;
      rsp             <= next_rsp;
      flash_reset_n   <= next_flash_reset_n;
      unprotect_hv_en <= next_unprotect_hv_en;
    end
  end

  // Checks: helper counters of reset-low and high-voltage time
  localparam int RST_LOW_MIN  = faas_pkg::RST_PULSE_CYC;
  localparam int HV_SETUP_MIN = faas_pkg::UNPROTECT_SETUP_CYC;
  logic [9:0] low_cnt;   // Cycles reset pin held low
  logic [9:0] hv_cnt;    // Cycles unprotect level applied

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      low_cnt <= 10'h000;
      hv_cnt  <= 10'h000;
    end
    else
    begin
      low_cnt <= flash_reset_n ? 10'h000 : low_cnt + ((&low_cnt) ? 10'h000 : 10'h001);
      hv_cnt  <= !unprotect_hv_en ? 10'h000 : hv_cnt + ((&hv_cnt) ? 10'h000 : 10'h001);
    end
  end

  property p_rst_pulse;
    @(posedge clk) disable iff (reset)
      $rose(flash_reset_n) |-> (int'($past(low_cnt)) >= RST_LOW_MIN - 1);
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too short");

  property p_rst_high;
    @(posedge clk) disable iff (reset)
      $rose(flash_reset_n) |-> flash_pins.ce_n [*3];
  endproperty
  a_rst_high: assert property (p_rst_high) else $error("access too soon after reset");

  property p_hv_setup;
    @(posedge clk) disable iff (reset)
      (unprotect_hv_en && !flash_pins.we_n) |-> (int'(hv_cnt) >= HV_SETUP_MIN);
  endproperty
  a_hv_setup: assert property (p_hv_setup) else $error("write before unprotect setup");

  property p_read_ready;
    @(posedge clk) disable iff (reset)
      (state == S_READ && cyc_start) |-> $past(ready_busy_n_out);
  endproperty
  a_read_ready: assert property (p_read_ready) else $error("array read while busy");

  property p_poll_reads;
    @(posedge clk) disable iff (reset)
      (state == S_POLL1 || state == S_POLL2) |-> flash_pins.we_n && !flash_pins.dq_oe;
  endproperty
  a_poll_reads: assert property (p_poll_reads) else $error("write during status poll");

  property p_rst_busy;
    @(posedge clk) disable iff (reset)
      $fell(flash_reset_n) |-> !req_ready [*8];
  endproperty
  a_rst_busy: assert property (p_rst_busy) else $error("request taken during reset");

  c_program: cover property (@(posedge clk) disable iff (reset)
    rsp_valid && op == faas_pkg::OP_PROGRAM && !rsp.timeout);
  c_sector: cover property (@(posedge clk) disable iff (reset)
    rsp_valid && op == faas_pkg::OP_SECTOR_ERASE);
  c_reset: cover property (@(posedge clk) disable iff (reset)
    rsp_valid && op == faas_pkg::OP_RESET);
  c_timeout: cover property (@(posedge clk) disable iff (reset)
    rsp_valid && rsp.timeout);

endmodule
`default_nettype wire

// file: shared/faas_pkg.sv
`default_nettype none
package faas_pkg;

  // System clock rate
  localparam int unsigned CLK_MHZ = 50;

  // Least time in ns to whole clock cycles, rounded up, never below one
  function automatic int unsigned min_cyc(input int unsigned t_ns);
    int unsigned c;
    c = (t_ns * CLK_MHZ + 999) / 1000;
    return (c == 0) ? 1 : c;
  endfunction

  // Pin, bus and timer widths, status and sector-select bit positions
  localparam int unsigned ADDR_W                = 19;
  localparam int unsigned DATA_W                = 8;
  localparam int unsigned TIMER_W               = 30;
  localparam int unsigned POLL_STATUS_BIT       = 7;
  localparam int unsigned TOGGLE_STATUS_BIT     = 6;
  localparam int unsigned SECTOR_SELECT_LOW_BIT = 13;
  localparam int unsigned SECTOR_SELECT_HIGH_BIT = 18;

  // Reset and unprotect timing, in printed units
  localparam int unsigned RST_PULSE_NS        = 500;
  localparam int unsigned RST_HIGH_NS         = 50;
  localparam int unsigned READY_ALGO_US       = 20;
  localparam int unsigned UNPROTECT_SETUP_US  = 4;
  localparam int unsigned UNPROTECT_RAMP_NS   = 500;
  localparam int unsigned RST_PULSE_CYC       = min_cyc(RST_PULSE_NS);
  localparam int unsigned RST_HIGH_CYC        = min_cyc(RST_HIGH_NS);
  localparam int unsigned READY_ALGO_CYC      = min_cyc(READY_ALGO_US * 1000);
  localparam int unsigned UNPROTECT_SETUP_CYC = min_cyc(UNPROTECT_SETUP_US * 1000);
  localparam int unsigned UNPROTECT_RAMP_CYC  = min_cyc(UNPROTECT_RAMP_NS);

  // Bus cycle timing
  localparam int unsigned WRITE_PULSE_NS    = 35;
  localparam int unsigned WRITE_HIGH_NS     = 30;
  localparam int unsigned READ_ACCESS_NS    = 90;
  localparam int unsigned WRITE_PULSE_CYC   = min_cyc(WRITE_PULSE_NS);
  localparam int unsigned RECOVER_CYC       = min_cyc(WRITE_HIGH_NS);
  localparam int unsigned READ_ACCESS_CYC   = min_cyc(READ_ACCESS_NS);

  // Longest algorithm times, used as poll time-outs
  localparam int unsigned PROG_MAX_US        = 300;
  localparam int unsigned ERASE_MAX_S        = 15;
  localparam int unsigned PROG_TIMEOUT_CYC   = PROG_MAX_US * CLK_MHZ;
  localparam int unsigned ERASE_TIMEOUT_CYC  = ERASE_MAX_S * CLK_MHZ * 1000000;

  // Command sequence words
  localparam logic [18:0] UNLOCK_ADDR1     = 19'h00555;
  localparam logic [18:0] UNLOCK_ADDR2     = 19'h002aa;
  localparam logic [7:0]  UNLOCK_DATA1     = 8'haa;
  localparam logic [7:0]  UNLOCK_DATA2     = 8'h55;
  localparam logic [7:0]  CMD_PROGRAM      = 8'ha0;
  localparam logic [7:0]  CMD_ERASE_SETUP  = 8'h80;
  localparam logic [7:0]  CMD_CHIP_ERASE   = 8'h10;
  localparam logic [7:0]  CMD_SECTOR_ERASE = 8'h30;
  localparam logic [2:0]  PROG_SEQ_LAST    = 3'h3;
  localparam logic [2:0]  ERASE_SEQ_LAST   = 3'h5;

  // Operations the user may request
  typedef enum logic [2:0] {
    OP_READ,
    OP_PROGRAM,
    OP_CHIP_ERASE,
    OP_SECTOR_ERASE,
    OP_RESET,
    OP_UNPROT_ON,
    OP_UNPROT_OFF
  } faas_op_t;

  typedef struct packed {
    faas_op_t    op;
    logic [18:0] addr;
    logic [7:0]  data;
  } faas_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic       timeout;
  } faas_rsp_t;

  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [18:0] addr;
    logic [7:0]  dq_o;
    logic        dq_oe;
  } faas_pins_t;

  localparam faas_pins_t PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                       addr: 19'h00000, dq_o: 8'h00, dq_oe: 1'b0};

endpackage
`default_nettype wire

// file: sim/faas_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural flash device on the far side of the host
module faas_flash_model
(
  input  wire logic                 clk,
  input  wire faas_pkg::faas_pins_t pins,
  input  wire logic                 flash_reset_n,
  input  var  int                   busy_len,
  output logic [7:0]                dq_i,
  output logic                      ready_busy_n_out
);
  logic [7:0]  mem [int]; // Sparse array, absent means erased
  logic [39:0] hist = '0; // Last command bytes
  logic        arm = 0;   // Next write is program data
  logic        pgm = 0;   // Running algorithm is a program
  logic [7:0]  pd = '0;   // Byte being programmed
  logic [7:0]  drv = '0;  // Model drive on the data lines
  logic        tog = 0;   // Toggle status
  int          cnt = 0;   // Busy cycles left
  logic        we_q = 1;  // Previous write strobe
  logic        oe_q = 1;  // Previous output strobe

  // Wire level: host wins while it drives
  assign dq_i = pins.dq_oe ? pins.dq_o : drv;
  assign ready_busy_n_out = (cnt == 0);

  // Command decode, algorithm timer, read data
  always @(posedge clk)
  begin
    we_q <= pins.we_n;
    oe_q <= pins.oe_n;
    if (cnt > 0)
      cnt <= cnt - 1;
    if (!flash_reset_n)
    begin
      cnt <= 0;
      hist <= '0;
      arm <= 0;
    end
    else if (cnt == 0 && !pins.we_n && we_q && !pins.ce_n)
    begin
      hist <= {hist[31:0], pins.dq_o};
      arm <= 0;
      // Whole byte stored at start; an aborted program still leaves it written
      if (arm)
      begin
        pgm <= 1;
        pd <= pins.dq_o;
        cnt <= busy_len;
        mem[pins.addr] = mem.exists(pins.addr) ? mem[pins.addr] & pins.dq_o : pins.dq_o;
      end
      else if (hist[15:0] == 16'haa55 && pins.dq_o == 8'ha0)
        arm <= 1;
      else if (hist == 40'haa5580aa55 && (pins.dq_o == 8'h10 || pins.dq_o == 8'h30))
      begin
        pgm <= 0;
        cnt <= busy_len;
        foreach (mem[k])
          if (pins.dq_o == 8'h10 || k[18:13] == pins.addr[18:13])
            mem[k] = 8'hff;
      end
    end
    // Status replaces array data while busy
    if (!pins.ce_n && !pins.oe_n)
      drv <= (cnt > 0) ? {pgm ? ~pd[7] : 1'b0, tog, 6'h15}
           : (mem.exists(pins.addr) ? mem[pins.addr] : 8'hff);
    else
      drv <= ~drv; // Released lines do not hold
    if (pins.oe_n && !oe_q && cnt > 0)
      tog <= ~tog;
  end
endmodule
`default_nettype wire

// file: sim/faas_host_bench.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the flash host
module faas_host_bench;
  logic                 clk = 0;
  logic                 reset = 1;
  logic                 req_valid = 0;
  faas_pkg::faas_req_t  req = '0;
  logic                 req_ready;
  logic                 rsp_valid;
  faas_pkg::faas_rsp_t  rsp;
  faas_pkg::faas_pins_t flash_pins;
  logic [7:0]           dq_i;
  logic                 rdy;
  logic                 flash_reset_n;
  logic                 unprotect_hv_en;
  int                   busy_len = 20;  // Model algorithm length
  int                   num_errors = 0;
  int                   n_compared = 0;
  int                   low_cnt = 0;    // Running reset low count
  int                   rst_w = 0;      // Last reset low width
  logic [31:0]          seed = 32'hb888;
  logic [7:0]           shadow [int];   // Expected array contents

  faas_host #(.PROG_TIMEOUT_CYC(200), .ERASE_TIMEOUT_CYC(400)) i_faas_host (
    .clk(clk), .reset(reset), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .flash_pins(flash_pins), .dq_i(dq_i),
    .ready_busy_n_out(rdy), .flash_reset_n(flash_reset_n), .unprotect_hv_en(unprotect_hv_en));
  faas_flash_model i_faas_flash_model (.clk(clk), .pins(flash_pins),
    .flash_reset_n(flash_reset_n), .busy_len(busy_len), .dq_i(dq_i), .ready_busy_n_out(rdy));

  initial
  begin
    forever #10 clk = ~clk;
  end

  // Width of each flash reset pulse
  always @(posedge clk)
  begin
    if (flash_reset_n === 1'b0)
      low_cnt <= low_cnt + 1;
    else if (low_cnt != 0)
    begin
      rst_w <= low_cnt;
      low_cnt <= 0;
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Array byte after a program on top of what is there
  function automatic logic [7:0] exp_byte(input logic [18:0] a, input logic [7:0] d);
    return shadow.exists(a) ? shadow[a] & d : d;
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One request, held until taken, then wait for the answer
  task automatic op(input faas_pkg::faas_op_t o, input logic [18:0] a, input logic [7:0] d,
                    output int n);
    @(negedge clk);
    req_valid = 1;
    req = '{op: o, addr: a, data: d};
    while (req_ready !== 1'b1)
      @(negedge clk);
    @(negedge clk);
    req_valid = 0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 30000)
    begin
      @(negedge clk);
      n++;
    end
    check("rsp_valid", rsp_valid, 1);
  endtask

  task automatic complete_run;
    if (num_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard, well beyond the expected few thousand cycles
  initial
  begin
    #1000000;
    num_errors++;
    complete_run();
  end

  initial
  begin
    int          n;
    logic [18:0] a;
    logic [7:0]  d;
    repeat (2) @(negedge clk);
    reset = 0;
    op(faas_pkg::OP_RESET, '0, '0, n);
    check("reset_width", rst_w >= faas_pkg::RST_PULSE_CYC, 1);
    check("reset_wait", n + 2 >= faas_pkg::READY_ALGO_CYC, 1);
    busy_len = 100;
    op(faas_pkg::OP_CHIP_ERASE, '0, '0, n);
    check("erase_status", rsp, 9'h1fe);
    // Corner bytes first, then random ones
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(lfsr(seed));
      a = (i < 2) ? {19{i[0]}} : seed[18:0];
      d = (i < 2) ? {i[0], 7'h00} : seed[26:19];
      busy_len = 10 + seed[5:0];
      op(faas_pkg::OP_PROGRAM, a, d, n);
      check("prog_status", rsp, {exp_byte(a, d), 1'b0});
      shadow[a] = exp_byte(a, d);
      op(faas_pkg::OP_READ, a, '0, n);
      check("read_back", rsp.data, shadow[a]);
    end
    op(faas_pkg::OP_SECTOR_ERASE, 19'h7e000, '0, n);
    check("sector_status", rsp, 9'h1fe);
    op(faas_pkg::OP_READ, 19'h7ffff, '0, n);
    check("erased_byte", rsp.data, 8'hff);
    op(faas_pkg::OP_READ, 19'h00000, '0, n);
    check("kept_byte", rsp.data, shadow[0]);
    busy_len = 1000;
    op(faas_pkg::OP_PROGRAM, 19'h00100, 8'h5a, n);
    check("slow_timeout", rsp.timeout, 1);
    op(faas_pkg::OP_RESET, '0, '0, n);
    check("abort_ready", {rsp.timeout, rdy}, 2'b01);
    busy_len = 15;
    op(faas_pkg::OP_UNPROT_ON, '0, '0, n);
    check("hv_on", unprotect_hv_en, 1);
    check("hv_setup", n + 2 >= faas_pkg::UNPROTECT_SETUP_CYC, 1);
    op(faas_pkg::OP_PROGRAM, 19'h40000, 8'h3c, n);
    check("unprot_prog", rsp, {exp_byte(19'h40000, 8'h3c), 1'b0});
    op(faas_pkg::OP_UNPROT_OFF, '0, '0, n);
    check("hv_off", unprotect_hv_en, 0);
    complete_run();
  end
endmodule
`default_nettype wire
